// ### core/sac_cfg.svh
// Purpose: constants for the converter control port
// Assumes: 20 MHz system clock, synchronous pin inputs
// Notes  : counts derive from times; least times round up
//
// Operation
// - select low sleeps, high naps on shutdown
// - power-down low enters the selected shutdown
// - drive data only while read and select low; the enable here lags both strobes by one clock
// - convert-start falling edge begins a conversion
// - strobes ignored unless chip select is low
// - busy low throughout conversion, high otherwise
// - result valid on data by busy rise
// - result is one 12-bit parallel three-state word
// - clear approximation register at conversion start
// - started conversion completes, restarts ignored
// - decide bits one per step, MSB first
// - copy finished result into output latches
// - result in two's complement, span over 4096
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// word and clock
`define SAC_RES_BITS    12
`define SAC_CLK_MHZ     20
`define SAC_FIFO_DEPTH  8
// one bit decision per step
`define SAC_BIT_NS      50
`define SAC_BIT_CYC     ((`SAC_BIT_NS * `SAC_CLK_MHZ + 999) / 1000)
// wake-up from deep sleep before a start is honoured
`define SAC_WAKE_NS     200
`define SAC_WAKE_CYC    ((`SAC_WAKE_NS * `SAC_CLK_MHZ + 999) / 1000)
// codes and indices
`define SAC_MSB_IDX     4'hB
`define SAC_LSB_IDX     4'h0
`define SAC_RESULT_RST  12'h000
`define SAC_TRIAL_MID   12'h800
`define SAC_CNT_ONE     4'h1
`define SAC_CNT_ZERO    4'h0

`endif

// ### core/sac_fifo.sv
// Purpose: result buffer between converter and stream sink
// Assumes: one clock, async active-high reset
// Notes  : count-based full and empty, no bypass
`timescale 1ns/1ns

module sac_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // storage words
  logic [AW-1:0]    wr_ptr;        // next write slot
  logic [AW-1:0]    rd_ptr;        // oldest word
  logic [AW:0]      count;         // words held
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // pointers wrap at depth, count tracks occupancy
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  // storage needs no reset
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule : sac_fifo

// ### core/sac_pkg.sv
// Purpose: shared types of the converter control port
// Assumes: constants come from the cfg header
// Notes  : types only
`include "sac_cfg.svh"

package sac_pkg;

  // sequencer states
  typedef enum logic [2:0]
  {
    SAC_IDLE,
    SAC_SAMPLE,
    SAC_BITS,
    SAC_FINISH,
    SAC_NAP,
    SAC_SLEEP,
    SAC_WAKE
  } sac_state_t;

  // one conversion word
  typedef logic [`SAC_RES_BITS-1:0] sac_word_t;

endpackage : sac_pkg

// ### core/sac_port.sv
// Purpose: control and parallel output of a 12-bit successive-approximation converter
// Assumes: pin inputs synchronous to clock; comparator answers
//          combinationally to trial_code within one step
// Notes  : every result also goes to a buffered stream port
`timescale 1ns/1ns

// constants are named in the shared header; its guard makes a repeat include harmless
`include "sac_cfg.svh"

module sac_port
  import sac_pkg::*;
#(
  parameter int BIT_CYC  = `SAC_BIT_CYC,
  parameter int WAKE_CYC = `SAC_WAKE_CYC,
  parameter int DEPTH    = `SAC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // host strobes
  input  wire logic                     chip_select_n,
  input  wire logic                     read_n,
  input  wire logic                     convert_start_n,
  // shutdown pins
  input  wire logic                     power_down_n,
  input  wire logic                     sleep_depth_select,
  // comparator and dac
  input  wire logic                     compare_keep,
  output logic      [`SAC_RES_BITS-1:0] trial_code,
  // status
  output logic                          busy,
  output logic                          nap_active,
  output logic                          sleep_active,
  // three-state data port
  output logic      [`SAC_RES_BITS-1:0] result_bits,
  output logic                          result_bits_oe,
  // result stream
  output logic                          stream_valid,
  input  wire logic                     stream_ready,
  output logic      [`SAC_RES_BITS-1:0] stream_data
);

  ////////////////////////////////////////////////////////////////
  // functions
  ////////////////////////////////////////////////////////////////

  // one-hot weight of a bit index
  function automatic sac_word_t bit_mask(input logic [3:0] idx);
    sac_word_t m;
    m = '0;
    m[idx] = 1'b1;
    return m;
  endfunction : bit_mask

  // offset binary to two's complement: flip the sign bit
  function automatic sac_word_t to_twos(input sac_word_t code);
    return code ^ `SAC_TRIAL_MID;
  endfunction : to_twos

  ////////////////////////////////////////////////////////////////
  // state
  ////////////////////////////////////////////////////////////////

  sac_state_t state;              // sequencer state
  sac_state_t next_state;         // sequencer next state
  logic       start_prev;         // last seen convert_start_n
  sac_word_t  approx_reg;         // approximation register
  sac_word_t  next_approx;        // its next value
  sac_word_t  next_trial;         // next dac trial code
  logic [3:0] bit_idx;            // bit under decision
  logic [3:0] next_bit_idx;       // its next value
  logic [3:0] step_cnt;           // bit step divider
  logic [3:0] wake_cnt;           // deep sleep wake count
  sac_word_t  fifo_data;          // buffer head word
  logic       fifo_valid;         // buffer head present
  logic       fifo_in_ready;      // buffer has room

  ////////////////////////////////////////////////////////////////
  // decode
  ////////////////////////////////////////////////////////////////

  // a start only counts with chip select low
  wire start_fall = start_prev && !convert_start_n && !chip_select_n;

  // port drives the pins one clock after both strobes are low
  wire read_on    = !chip_select_n && !read_n;

  // divider gives one step enable every BIT_CYC cycles
  wire step_en    = (step_cnt == `SAC_CNT_ZERO);

  // last bit reached
  wire last_bit   = (bit_idx == `SAC_LSB_IDX);

  // decision folded into the register for this step
  wire [`SAC_RES_BITS-1:0] decided =
    compare_keep ? (approx_reg | bit_mask(bit_idx)) : approx_reg;

  // finish stalls while the buffer is full, so back-pressure
  // reaches the converter instead of dropping a result
  wire finish_go  = (state == SAC_FINISH) && fifo_in_ready;

  // shutdown target follows the select pin live
  wire sac_state_t down_state =
    sleep_depth_select ? SAC_NAP : SAC_SLEEP;

  // conversion states hold busy low
  wire next_conv  = (next_state == SAC_SAMPLE) ||
                    (next_state == SAC_BITS) ||
                    (next_state == SAC_FINISH);

  // drain register accepts when empty or being emptied
  wire drain_take = fifo_valid && (!stream_valid || stream_ready);

  ////////////////////////////////////////////////////////////////
  // next state
  ////////////////////////////////////////////////////////////////

  // sequencer; shutdown is only taken between conversions
  always_comb
  begin
    next_state = state;
    case (state)
      // a shutdown request wins over a start seen in the same cycle
      SAC_IDLE:
      begin
        if (!power_down_n)
          next_state = down_state;
        else if (start_fall)
          next_state = SAC_SAMPLE;
      end
      // one cycle to clear the register and put the msb on trial
      SAC_SAMPLE:
        next_state = SAC_BITS;
      SAC_BITS:
      begin
        // start edges are not looked at here
        if (step_en && last_bit)
          next_state = SAC_FINISH;
      end
      // a full buffer holds the result here, and busy stays low
      SAC_FINISH:
      begin
        if (fifo_in_ready)
          next_state = SAC_IDLE;
      end
      // shutdown holds while power-down stays low; only deep sleep
      // pays the wake-up count before starts are honoured again
      SAC_NAP,
      SAC_SLEEP:
      begin
        if (!power_down_n)
          next_state = down_state;
        else if (state == SAC_SLEEP)
          next_state = SAC_WAKE;
        else
          next_state = SAC_IDLE;
      end
      SAC_WAKE:
      begin
        // starts during wake-up are ignored
        if (!power_down_n)
          next_state = down_state;
        else if (wake_cnt == `SAC_CNT_ZERO)
          next_state = SAC_IDLE;
      end
      // unused codes fall back to idle
      default:
        next_state = SAC_IDLE;
    endcase
  end

  // approximation register and trial code
  always_comb
  begin
    next_approx  = approx_reg;
    next_trial   = trial_code;
    next_bit_idx = bit_idx;
    case (state)
      SAC_SAMPLE:
      begin
        // start from zero with the msb on trial
        next_approx  = `SAC_RESULT_RST;
        next_trial   = `SAC_TRIAL_MID;
        next_bit_idx = `SAC_MSB_IDX;
      end
      SAC_BITS:
      begin
        if (step_en)
        begin
          next_approx = decided;
          if (!last_bit)
          begin
            next_bit_idx = bit_idx - `SAC_CNT_ONE;
            next_trial   = decided | bit_mask(bit_idx - `SAC_CNT_ONE);
          end
          else
            next_trial = decided;
        end
      end
      // outside sampling and bits the register and trial hold
      default:
      begin
        next_approx  = approx_reg;
        next_trial   = trial_code;
        next_bit_idx = bit_idx;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // registers
  ////////////////////////////////////////////////////////////////

  // sequencer and edge memory
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state      <= SAC_IDLE;
      start_prev <= 1'b1;
    end
    else
    begin
      state      <= next_state;
      start_prev <= convert_start_n;
    end
  end

  // approximation datapath
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      approx_reg <= `SAC_RESULT_RST;
      trial_code <= `SAC_RESULT_RST;
      bit_idx    <= `SAC_MSB_IDX;
    end
    else
    begin
      approx_reg <= next_approx;
      trial_code <= next_trial;
      bit_idx    <= next_bit_idx;
    end
  end

  // bit step divider, restarted as the bits begin
  // with a one-cycle step the count stays at zero and every cycle decides
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      step_cnt <= `SAC_CNT_ZERO;
    else if (state != SAC_BITS || step_en)
      step_cnt <= 4'(BIT_CYC - 1);
    else
      step_cnt <= step_cnt - `SAC_CNT_ONE;
  end

  // wake-up count; only deep sleep pays for it
  // trade-off: a fixed count instead of a settle detector keeps it small
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wake_cnt <= `SAC_CNT_ZERO;
    else if (state != SAC_WAKE)
      wake_cnt <= 4'(WAKE_CYC - 1);
    else if (wake_cnt != `SAC_CNT_ZERO)
      wake_cnt <= wake_cnt - `SAC_CNT_ONE;
  end

  // status pins follow the next state so they track pins
  // with the same single cycle of latency
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      busy         <= 1'b1;
      nap_active   <= 1'b0;
      sleep_active <= 1'b0;
    end
    else
    begin
      busy         <= !next_conv;
      nap_active   <= (next_state == SAC_NAP);
      sleep_active <= (next_state == SAC_SLEEP);
    end
  end

  // output latches load on the same edge that raises busy,
  // so the word is settled by the time busy is seen high
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      result_bits <= `SAC_RESULT_RST;
    else if (finish_go)
      result_bits <= to_twos(approx_reg);
  end

  // driver enable; released one clock after either strobe rises
  // limitation: the enable lags the strobes by one clock, so a host
  // sharing the lines leaves a cycle after raising a strobe
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      result_bits_oe <= 1'b0;
    else
      result_bits_oe <= read_on;
  end

  ////////////////////////////////////////////////////////////////
  // result buffer and stream register
  ////////////////////////////////////////////////////////////////

  // one word per finished conversion enters the buffer; a slow sink
  // loses no result, and only a full buffer stalls the converter
  sac_fifo #(
    .WIDTH (`SAC_RES_BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (state == SAC_FINISH),
    .in_ready  (fifo_in_ready),
    .in_data   (to_twos(approx_reg)),
    .out_valid (fifo_valid),
    .out_ready (drain_take),
    .out_data  (fifo_data)
  );

  // stream output held in flip-flops until the sink takes it
  // a new word moves in on the same edge the old one is taken
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stream_valid <= 1'b0;
      stream_data  <= `SAC_RESULT_RST;
    end
    else if (drain_take)
    begin
      stream_valid <= 1'b1;
      stream_data  <= fifo_data;
    end
    else if (stream_ready)
      stream_valid <= 1'b0;
  end

endmodule : sac_port

// ### sim/sac_far_model.sv
// Purpose: comparator and stream sink on the far side of the port
// Assumes: target holds still for a whole conversion
// Notes  : sink stalls at random, or fully while stall is high
`timescale 1ns/1ns

module sac_far_model
  import sac_pkg::*;
(
  // clock and controls
  input  wire logic      clock,
  input  wire logic      stall,
  input  wire sac_word_t target,
  // converter side
  input  wire sac_word_t trial_code,
  output logic           compare_keep,
  output logic           stream_ready
);
  // keep the trial bit while the trial is at or below the held input code
  assign compare_keep = (trial_code <= target);

  // random back pressure, moved off the sampling edge
  initial stream_ready = 1'b0;
  always @(negedge clock)
  begin
    stream_ready <= !stall && ($urandom_range(1, 0) == 1);
  end
endmodule : sac_far_model

// ### sim/sac_port_asserts.sv
// Purpose: concurrent checks on the converter control port pins
// Assumes: default BIT_CYC of 1, so a conversion keeps busy low 14 cycles
// Notes  : a full result buffer may stretch busy low, so only a bound is asserted
`timescale 1ns/1ns
`include "sac_cfg.svh"

module sac_port_chk
  import sac_pkg::*;
(
  // clock and reset
  input wire logic                     clock,
  input wire logic                     rst,
  // host strobes and shutdown pins
  input wire logic                     chip_select_n,
  input wire logic                     read_n,
  input wire logic                     convert_start_n,
  input wire logic                     power_down_n,
  input wire logic                     sleep_depth_select,
  // converter side
  input wire logic                     compare_keep,
  input wire logic [`SAC_RES_BITS-1:0] trial_code,
  input wire logic                     busy,
  input wire logic                     nap_active,
  input wire logic                     sleep_active,
  input wire logic [`SAC_RES_BITS-1:0] result_bits,
  input wire logic                     result_bits_oe,
  input wire logic                     stream_valid,
  input wire logic                     stream_ready,
  input wire logic [`SAC_RES_BITS-1:0] stream_data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // cycles since sleep; the wake-up spell after sleep hides starts
  logic [2:0] quiet;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst) quiet <= 3'h7;
    else if (sleep_active) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_drive; (!chip_select_n && !read_n) |=> result_bits_oe; endproperty
  a_drive: assert property (p_drive) else $error("data port not driven");
  property p_float; (chip_select_n || read_n) |=> !result_bits_oe; endproperty
  a_float: assert property (p_float) else $error("data port not floated");
  property p_start;
    ($fell(convert_start_n) && !chip_select_n && busy && power_down_n && !nap_active
      && !sleep_active && quiet == 3'h7) |=> !busy;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_ignore; (busy && (chip_select_n || convert_start_n)) |=> busy; endproperty
  a_ignore: assert property (p_ignore) else $error("busy fell without start");
  property p_low; $fell(busy) |-> !busy[*8] ##1 !busy[*6]; endproperty
  a_low: assert property (p_low) else $error("conversion cut short");
  property p_end; $fell(busy) |-> ##[14:600] busy; endproperty
  a_end: assert property (p_end) else $error("busy never rose");
  property p_latch; !$stable(result_bits) |-> $rose(busy); endproperty
  a_latch: assert property (p_latch) else $error("latch moved off busy rise");
  property p_msb; $fell(busy) |=> trial_code == 12'h800 ##1 trial_code[10:0] == 11'h400;
  endproperty
  a_msb: assert property (p_msb) else $error("trial order wrong");
  property p_mode;
    (!power_down_n && busy && !$rose(busy)) |=>
      nap_active == $past(sleep_depth_select) && sleep_active != $past(sleep_depth_select);
  endproperty
  a_mode: assert property (p_mode) else $error("wrong shutdown mode");
  property p_wake; power_down_n |=> !nap_active && !sleep_active; endproperty
  a_wake: assert property (p_wake) else $error("shutdown held");

  // main scenarios reached
  c_conv: cover property ($fell(busy));
  c_nap: cover property ($rose(nap_active));
  c_sleep: cover property ($rose(sleep_active));
endmodule : sac_port_chk

bind sac_port sac_port_chk u_chk (.*);

// ### sim/tb_top.sv
// Purpose: self-checking bench for the converter control port
// Assumes: inputs change on the falling edge; default design parameters
// Notes  : expected words queue up at each start and are matched as they appear
`timescale 1ns/1ns

`define CHK(nm, ex, got) begin num_checks++; if ((ex) !== (got)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module tb_top;
  import sac_pkg::*;
  // pins and bench state
  logic      clock, rst, chip_select_n, read_n, convert_start_n;
  logic      power_down_n, sleep_depth_select, stall, busy, nap_active, sleep_active;
  logic      compare_keep, stream_ready, stream_valid, result_bits_oe, prev_busy;
  sac_word_t trial_code, result_bits, stream_data, target, exp_w, exp_s;
  sac_word_t rq[$], sq[$];
  int        failures, num_checks, cycles, seed;

  ////////////////////////////////////////////////////////////////////////////
  sac_port dut (.clock(clock), .rst(rst), .chip_select_n(chip_select_n), .read_n(read_n),
    .convert_start_n(convert_start_n), .power_down_n(power_down_n),
    .sleep_depth_select(sleep_depth_select), .compare_keep(compare_keep),
    .trial_code(trial_code), .busy(busy), .nap_active(nap_active),
    .sleep_active(sleep_active), .result_bits(result_bits), .result_bits_oe(result_bits_oe),
    .stream_valid(stream_valid), .stream_ready(stream_ready), .stream_data(stream_data));
  sac_far_model far (.clock(clock), .stall(stall), .target(target),
    .trial_code(trial_code), .compare_keep(compare_keep), .stream_ready(stream_ready));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // verdict, reached from the main sequence or the watchdog
  task automatic end_of_test();
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // watchdog on a hung run
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      end_of_test();
    end
  end

  // latched word must be the oldest expectation when busy rises
  always @(negedge clock)
  begin
    if (busy === 1'b1 && prev_busy === 1'b0)
    begin
      exp_w = rq.pop_front();
      `CHK("result_bits", exp_w, result_bits)
    end
    prev_busy = busy;
  end

  // stream words are taken on the accepting edge, before it updates them;
  // the note is popped once so a mismatch cannot eat a second note
  always @(posedge clock)
  begin
    if (stream_valid === 1'b1 && stream_ready === 1'b1)
    begin
      exp_s = sq.pop_front();
      `CHK("stream_data", exp_s, stream_data)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wait for busy high under a bound; running out counts as a mismatch
  task automatic wait_busy(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < lim)
    begin
      @(negedge clock);
      n++;
    end
    if (busy !== 1'b1)
      failures++;
  endtask : wait_busy

  // one conversion of code t; again adds a start edge mid-conversion;
  // a lim of zero is a conversion that a full buffer is expected to hold back
  task automatic conv(input sac_word_t t, input bit again, input int lim);
    target = t;
    rq.push_back(t ^ 12'h800);
    sq.push_back(t ^ 12'h800);
    convert_start_n = 1'b0;
    @(negedge clock);
    convert_start_n = 1'b1;
    @(negedge clock);
    if (again)
    begin
      convert_start_n = 1'b0;
      @(negedge clock);
      convert_start_n = 1'b1;
    end
    if (lim > 0)
      wait_busy(lim);
    else
      repeat (20) @(negedge clock);
    repeat (2) @(negedge clock);
  endtask : conv

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, chip_select_n, read_n, convert_start_n, power_down_n} = 5'h1F;
    {sleep_depth_select, stall, target, failures, num_checks, cycles} = '0;
    seed = $urandom(88059);
    repeat (6) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    `CHK("oe", 1'b0, result_bits_oe)
    // start while deselected is ignored
    convert_start_n = 1'b0;
    @(negedge clock);
    convert_start_n = 1'b1;
    repeat (3) @(negedge clock);
    `CHK("busy", 1'b1, busy)
    chip_select_n = 1'b0;
    // corner codes, then random codes with stray start edges
    conv(12'h000, 1'b0, 40);
    conv(12'hFFF, 1'b1, 40);
    conv(12'h800, 1'b0, 40);
    conv(12'h7FF, 1'b0, 40);
    repeat (12) conv(12'($urandom), $urandom_range(1, 0) == 1, 40);
    // read strobe drives the port, release floats it
    read_n = 1'b0;
    @(negedge clock);
    `CHK("oe", 1'b1, result_bits_oe)
    `CHK("latch", exp_w, result_bits)
    read_n = 1'b1;
    @(negedge clock);
    `CHK("oe", 1'b0, result_bits_oe)
    // nap, then sleep, with a start refused meanwhile
    {sleep_depth_select, power_down_n} = 2'b10;
    repeat (2) @(negedge clock);
    `CHK("nap", 1'b1, nap_active)
    sleep_depth_select = 1'b0;
    repeat (2) @(negedge clock);
    `CHK("sleep", 1'b1, sleep_active)
    convert_start_n = 1'b0;
    @(negedge clock);
    convert_start_n = 1'b1;
    repeat (2) @(negedge clock);
    `CHK("busy", 1'b1, busy)
    // a start during the wake-up spell after sleep is refused too
    power_down_n = 1'b1;
    @(negedge clock);
    convert_start_n = 1'b0;
    @(negedge clock);
    convert_start_n = 1'b1;
    @(negedge clock);
    `CHK("busy", 1'b1, busy)
    repeat (8) @(negedge clock);
    conv(12'($urandom), 1'b0, 40);
    // let the sink empty the stream register, then fill the buffer
    // until a finished conversion is held back
    repeat (30) @(negedge clock);
    stall = 1'b1;
    repeat (9) conv(12'($urandom), 1'b0, 40);
    conv(12'($urandom), 1'b0, 0);
    `CHK("busy", 1'b0, busy)
    stall = 1'b0;
    wait_busy(400);
    repeat (60) @(negedge clock);
    `CHK("drained", 1'b0, stream_valid)
    `CHK("pending", 0, rq.size() + sq.size())
    end_of_test();
  end
endmodule : tb_top
